// ==== core/tlb_test_pkg.sv ====
// Constants, carriers and decode helpers for the TLB test access block
// How it works
// - A select write takes the main way from bit 31, the index from 14:10.
// - Only the main and lockdown transfers (CRm c7) use the entry in the select register.
// - Opcode_1 4 or 5, opcode_2 0: CRm c2 reads, c3 writes the main tag.
// - Tag word: virtual tag in 31:10, valid in bit 4, size code in 3:0.
// - Size codes 0001/0011/0101/0111/1011 are 1KB/4KB/16KB/64KB/1MB.
// - Opcode_2 0: CRm c4 reads, c5 writes the main physical word.
// - Physical word: address 31:10, domain 7:4, permission 3:2, C 1, B 0.
// - Permission 00 none, 01 privileged only, 10 adds user read, 11 all.
// - A write to CRm c7 opcode_2 0 copies main staging into the main entry.
// - Opcode_2 1: CRm c2 reads, c3 writes the lockdown tag, same layout.
// - Opcode_2 1: CRm c4 reads, c5 writes the lockdown physical word.
// - A write to CRm c7 opcode_2 1 copies lockdown staging into its entry.
// - A main transfer drives one copy to both ways, enabling one way only.
// - A lockdown transfer takes the entry from select bits 28 to 26.
package tlb_test_pkg;

  // ************************************************************
  // Operation encodings
  // ************************************************************
  localparam logic [3:0] CRN_TEST = 4'hf;
  localparam logic [3:0] CRM_SELECT = 4'h1;
  localparam logic [3:0] CRM_TAG_RD = 4'h2;
  localparam logic [3:0] CRM_TAG_WR = 4'h3;
  localparam logic [3:0] CRM_PHYS_RD = 4'h4;
  localparam logic [3:0] CRM_PHYS_WR = 4'h5;
  localparam logic [3:0] CRM_XFER = 4'h7;
  localparam logic [2:0] OP1_SELECT = 3'h0;
  localparam logic [2:0] OP1_TLB_A = 3'h4;
  localparam logic [2:0] OP1_TLB_B = 3'h5;
  localparam logic [2:0] OP2_MAIN = 3'h0;
  localparam logic [2:0] OP2_LOCK = 3'h1;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int WAY_BIT = 31;
  localparam int MAIN_IDX_LSB = 10;
  localparam int MAIN_IDX_W = 5;
  localparam int LOCK_IDX_LSB = 26;
  localparam int LOCK_IDX_W = 3;
  localparam int ADDR_LSB = 10;
  localparam int ADDR_W = 22;
  localparam int VALID_BIT = 4;
  localparam int SIZE_LSB = 0;
  localparam int SIZE_W = 4;
  localparam int DOM_LSB = 4;
  localparam int DOM_W = 4;
  localparam int PERM_LSB = 2;
  localparam int PERM_W = 2;
  localparam int C_BIT = 1;
  localparam int B_BIT = 0;
  localparam int ENTRY_W = 56;
  localparam int MAIN_WD_W = 112;

  // ************************************************************
  // Codes and reset values
  // ************************************************************
  localparam logic [3:0] SIZE_1K = 4'h1;
  localparam logic [3:0] SIZE_4K = 4'h3;
  localparam logic [3:0] SIZE_16K = 4'h5;
  localparam logic [3:0] SIZE_64K = 4'h7;
  localparam logic [3:0] SIZE_1M = 4'hb;
  localparam logic [1:0] PERM_NONE = 2'h0;
  localparam logic [1:0] PERM_PRIV = 2'h1;
  localparam logic [1:0] PERM_USER_RO = 2'h2;
  localparam logic [1:0] PERM_ALL = 2'h3;
  localparam logic [3:0] WE_WAY0 = 4'h3;
  localparam logic [3:0] WE_WAY1 = 4'hc;
  localparam logic [3:0] WE_NONE = 4'h0;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] opcode1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] opcode2;
    logic [31:0] wdata;
  } cp_op_t;

  typedef struct packed {
    logic priv_read;
    logic priv_write;
    logic user_read;
    logic user_write;
  } perm_t;

  // ************************************************************
  // Decode helpers
  // ************************************************************
  // size code check
  function automatic logic size_known(input logic [3:0] code);
    case (code)
      SIZE_1K, SIZE_4K, SIZE_16K, SIZE_64K, SIZE_1M: size_known = 1'b1;
      default: size_known = 1'b0;
    endcase
  endfunction : size_known

  function automatic perm_t perm_decode(input logic [1:0] code);
    perm_t p;
    p = '0;
    case (code)
      PERM_NONE: p = '0;
      PERM_PRIV: p = '{1'b1, 1'b1, 1'b0, 1'b0};
      PERM_USER_RO: p = '{1'b1, 1'b1, 1'b1, 1'b0};
      PERM_ALL: p = '{1'b1, 1'b1, 1'b1, 1'b1};
      default: p = '0;
    endcase
    perm_decode = p;
  endfunction : perm_decode

endpackage : tlb_test_pkg

// ==== core/tlb_entry_pack.sv ====
// Packs a staged tag word and physical word into one TLB RAM entry
`timescale 1ns/100ps
`default_nettype none
module tlb_entry_pack
  import tlb_test_pkg::*;
(
  input wire logic [31:0] tag_word_i,
  input wire logic [31:0] phys_word_i,
  output logic [ENTRY_W-1:0] entry_o
);

  // ************************************************************
  // Entry layout: tag, size, address, domain, permission, C, B
  // ************************************************************
  // tag fields
  assign entry_o = {tag_word_i[ADDR_LSB +: ADDR_W],
                    tag_word_i[SIZE_LSB +: SIZE_W],
                    phys_word_i[ADDR_LSB +: ADDR_W],
                    phys_word_i[DOM_LSB +: DOM_W],
                    phys_word_i[PERM_LSB +: PERM_W],
                    phys_word_i[C_BIT],
                    phys_word_i[B_BIT]};

endmodule : tlb_entry_pack
`default_nettype wire

// ==== core/tlb_test_access.sv ====
// Coprocessor test access to the main and lockdown TLB RAMs
`timescale 1ns/100ps
`default_nettype none
module tlb_test_access
  import tlb_test_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire cp_op_t cp_op_i,
  output logic [31:0] cp_rdata_o,
  output logic cp_rvalid_o,
  output logic main_ram_cs_o,
  output logic [MAIN_IDX_W-1:0] main_ram_addr_o,
  output logic [3:0] main_ram_we_o,
  output logic [MAIN_WD_W-1:0] main_ram_wd_o,
  output logic lock_ram_cs_o,
  output logic [LOCK_IDX_W-1:0] lock_ram_addr_o,
  output logic [ENTRY_W-1:0] lock_ram_wd_o,
  output logic main_tag_valid_o,
  output logic main_size_known_o,
  output perm_t main_perm_o
);

  // ************************************************************
  // State
  // ************************************************************
  logic [31:0] test_entry_select;
  logic [31:0] main_tag_staging;
  logic [31:0] main_phys_perm_staging;
  logic [31:0] lockdown_tag_staging;
  logic [31:0] lockdown_phys_perm_staging;
  logic [31:0] cp_rdata;
  logic cp_rvalid;
  logic main_ram_cs;
  logic [MAIN_IDX_W-1:0] main_ram_addr;
  logic [3:0] main_ram_we;
  logic [MAIN_WD_W-1:0] main_ram_wd;
  logic lock_ram_cs;
  logic [LOCK_IDX_W-1:0] lock_ram_addr;
  logic [ENTRY_W-1:0] lock_ram_wd;
  logic main_tag_valid;
  logic main_size_known;
  perm_t main_perm;

  logic [31:0] next_test_entry_select;
  logic [31:0] next_main_tag_staging;
  logic [31:0] next_main_phys_perm_staging;
  logic [31:0] next_lockdown_tag_staging;
  logic [31:0] next_lockdown_phys_perm_staging;
  logic [31:0] next_cp_rdata;
  logic next_cp_rvalid;
  logic next_main_ram_cs;
  logic [MAIN_IDX_W-1:0] next_main_ram_addr;
  logic [3:0] next_main_ram_we;
  logic [MAIN_WD_W-1:0] next_main_ram_wd;
  logic next_lock_ram_cs;
  logic [LOCK_IDX_W-1:0] next_lock_ram_addr;
  logic [ENTRY_W-1:0] next_lock_ram_wd;
  logic next_main_tag_valid;
  logic next_main_size_known;
  perm_t next_main_perm;

  // ************************************************************
  // Operation decode
  // ************************************************************
  logic op_ours;
  logic op_select;
  logic op_tlb;
  logic op_main;
  logic op_lock;
  logic [ENTRY_W-1:0] main_entry;
  logic [ENTRY_W-1:0] lock_entry;

  assign op_ours = cp_op_i.valid && (cp_op_i.crn == CRN_TEST);
  assign op_select = op_ours && (cp_op_i.opcode1 == OP1_SELECT)
                     && (cp_op_i.crm == CRM_SELECT)
                     && (cp_op_i.opcode2 == OP2_MAIN);
  assign op_tlb = op_ours && ((cp_op_i.opcode1 == OP1_TLB_A)
                  || (cp_op_i.opcode1 == OP1_TLB_B));
  assign op_main = op_tlb && (cp_op_i.opcode2 == OP2_MAIN);
  assign op_lock = op_tlb && (cp_op_i.opcode2 == OP2_LOCK);

  // ************************************************************
  // Entry packing
  // ************************************************************
  tlb_entry_pack main_pack (
    .tag_word_i(main_tag_staging),
    .phys_word_i(main_phys_perm_staging),
    .entry_o(main_entry)
  );

  tlb_entry_pack lock_pack (
    .tag_word_i(lockdown_tag_staging),
    .phys_word_i(lockdown_phys_perm_staging),
    .entry_o(lock_entry)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_test_entry_select = test_entry_select;
    next_main_tag_staging = main_tag_staging;
    next_main_phys_perm_staging = main_phys_perm_staging;
    next_lockdown_tag_staging = lockdown_tag_staging;
    next_lockdown_phys_perm_staging = lockdown_phys_perm_staging;
    next_cp_rdata = WORD_RESET;
    next_cp_rvalid = 1'b0;
    next_main_ram_cs = 1'b0;
    next_main_ram_we = WE_NONE;
    next_main_ram_addr = main_ram_addr;
    next_main_ram_wd = main_ram_wd;
    next_lock_ram_cs = 1'b0;
    next_lock_ram_addr = lock_ram_addr;
    next_lock_ram_wd = lock_ram_wd;

    // Test address register; SBZ bits are kept but never used
    if (op_select) begin
      if (cp_op_i.write) begin
        next_test_entry_select = cp_op_i.wdata;
      end else begin
        next_cp_rdata = test_entry_select;
        next_cp_rvalid = 1'b1;
      end
    end

    if (op_main) begin
      case (cp_op_i.crm)
        CRM_TAG_RD: begin
          next_cp_rdata = main_tag_staging;
          next_cp_rvalid = !cp_op_i.write;
        end
        CRM_TAG_WR: begin
          if (cp_op_i.write) begin
            next_main_tag_staging = cp_op_i.wdata;
          end
        end
        CRM_PHYS_RD: begin
          next_cp_rdata = main_phys_perm_staging;
          next_cp_rvalid = !cp_op_i.write;
        end
        CRM_PHYS_WR: begin
          if (cp_op_i.write) begin
            next_main_phys_perm_staging = cp_op_i.wdata;
          end
        end
        CRM_XFER: begin
          if (cp_op_i.write) begin
            next_main_ram_cs = 1'b1;
            next_main_ram_addr =
              test_entry_select[MAIN_IDX_LSB +: MAIN_IDX_W];
            next_main_ram_we = test_entry_select[WAY_BIT] ? WE_WAY1
                                                          : WE_WAY0;
            next_main_ram_wd = {main_entry, main_entry};
          end
        end
        default: begin
          next_cp_rvalid = 1'b0;
        end
      endcase
    end

    if (op_lock) begin
      case (cp_op_i.crm)
        CRM_TAG_RD: begin
          next_cp_rdata = lockdown_tag_staging;
          next_cp_rvalid = !cp_op_i.write;
        end
        CRM_TAG_WR: begin
          if (cp_op_i.write) begin
            next_lockdown_tag_staging = cp_op_i.wdata;
          end
        end
        CRM_PHYS_RD: begin
          next_cp_rdata = lockdown_phys_perm_staging;
          next_cp_rvalid = !cp_op_i.write;
        end
        CRM_PHYS_WR: begin
          if (cp_op_i.write) begin
            next_lockdown_phys_perm_staging = cp_op_i.wdata;
          end
        end
        CRM_XFER: begin
          if (cp_op_i.write) begin
            next_lock_ram_cs = 1'b1;
            next_lock_ram_addr =
              test_entry_select[LOCK_IDX_LSB +: LOCK_IDX_W];
            next_lock_ram_wd = lock_entry;
          end
        end
        default: begin
          next_cp_rvalid = 1'b0;
        end
      endcase
    end

    // Main entry status follows the main staging words as they change
    // valid flag
    next_main_tag_valid = next_main_tag_staging[VALID_BIT];
    next_main_size_known =
      size_known(next_main_tag_staging[SIZE_LSB +: SIZE_W]);
    next_main_perm =
      perm_decode(next_main_phys_perm_staging[PERM_LSB +: PERM_W]);
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      test_entry_select <= WORD_RESET;
      main_tag_staging <= WORD_RESET;
      main_phys_perm_staging <= WORD_RESET;
      lockdown_tag_staging <= WORD_RESET;
      lockdown_phys_perm_staging <= WORD_RESET;
      cp_rdata <= WORD_RESET;
      cp_rvalid <= 1'b0;
      main_ram_cs <= 1'b0;
      main_ram_addr <= '0;
      main_ram_we <= WE_NONE;
      main_ram_wd <= '0;
      lock_ram_cs <= 1'b0;
      lock_ram_addr <= '0;
      lock_ram_wd <= '0;
      main_tag_valid <= 1'b0;
      main_size_known <= 1'b0;
      main_perm <= '0;
    end else begin
      test_entry_select <= next_test_entry_select;
      main_tag_staging <= next_main_tag_staging;
      main_phys_perm_staging <= next_main_phys_perm_staging;
      lockdown_tag_staging <= next_lockdown_tag_staging;
      lockdown_phys_perm_staging <= next_lockdown_phys_perm_staging;
      cp_rdata <= next_cp_rdata;
      cp_rvalid <= next_cp_rvalid;
      main_ram_cs <= next_main_ram_cs;
      main_ram_addr <= next_main_ram_addr;
      main_ram_we <= next_main_ram_we;
      main_ram_wd <= next_main_ram_wd;
      lock_ram_cs <= next_lock_ram_cs;
      lock_ram_addr <= next_lock_ram_addr;
      lock_ram_wd <= next_lock_ram_wd;
      main_tag_valid <= next_main_tag_valid;
      main_size_known <= next_main_size_known;
      main_perm <= next_main_perm;
    end
  end

  assign cp_rdata_o = cp_rdata;
  assign cp_rvalid_o = cp_rvalid;
  assign main_ram_cs_o = main_ram_cs;
  assign main_ram_addr_o = main_ram_addr;
  assign main_ram_we_o = main_ram_we;
  assign main_ram_wd_o = main_ram_wd;
  assign lock_ram_cs_o = lock_ram_cs;
  assign lock_ram_addr_o = lock_ram_addr;
  assign lock_ram_wd_o = lock_ram_wd;
  assign main_tag_valid_o = main_tag_valid;
  assign main_size_known_o = main_size_known;
  assign main_perm_o = main_perm;

endmodule : tlb_test_access
`default_nettype wire

// ==== dv/tlb_test_access_sva.sv ====
// Assertion checker for the TLB test access block
`timescale 1ns/100ps
`default_nettype none
module tlb_test_access_sva
  import tlb_test_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire cp_op_t cp_op_i,
  input wire logic cp_rvalid_o,
  input wire logic main_ram_cs_o,
  input wire logic [MAIN_IDX_W-1:0] main_ram_addr_o,
  input wire logic [3:0] main_ram_we_o,
  input wire logic [MAIN_WD_W-1:0] main_ram_wd_o,
  input wire logic lock_ram_cs_o,
  input wire logic [LOCK_IDX_W-1:0] lock_ram_addr_o,
  input wire perm_t main_perm_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  logic tk, tl, so, rd_ok, xm, xl;
  logic [31:0] sel_q;
  logic [3:0] mw_q;
  logic [4:0] ma_q;
  logic [2:0] la_q;
  assign tk = cp_op_i.valid && cp_op_i.crn == CRN_TEST;
  assign tl = tk && cp_op_i.opcode2 inside {OP2_MAIN, OP2_LOCK}
    && cp_op_i.opcode1 inside {OP1_TLB_A, OP1_TLB_B};
  assign so = tk && cp_op_i.opcode1 == OP1_SELECT
    && cp_op_i.crm == CRM_SELECT && cp_op_i.opcode2 == OP2_MAIN;
  assign rd_ok = !cp_op_i.write
    && (so || (tl && cp_op_i.crm inside {CRM_TAG_RD, CRM_PHYS_RD}));
  assign xm = cp_op_i.write && tl && cp_op_i.crm == CRM_XFER
    && cp_op_i.opcode2 == OP2_MAIN;
  assign xl = cp_op_i.write && tl && cp_op_i.crm == CRM_XFER
    && cp_op_i.opcode2 == OP2_LOCK;
  // Target as of the taking edge, so a later select write is not seen
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sel_q <= 32'h0;
      mw_q <= 4'h0;
      ma_q <= 5'h0;
      la_q <= 3'h0;
    end else begin
      if (so && cp_op_i.write) sel_q <= cp_op_i.wdata;
      if (xm) mw_q <= sel_q[31] ? WE_WAY1 : WE_WAY0;
      if (xm) ma_q <= sel_q[14:10];
      if (xl) la_q <= sel_q[28:26];
    end
  end
  property p_rd_ans;
    rd_ok |=> cp_rvalid_o;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read answer missing");
  property p_no_ans;
    !rd_ok |=> !cp_rvalid_o;
  endproperty
  a_no_ans: assert property (p_no_ans)
    else $error("unexpected read answer");
  property p_main_xfer;
    xm |=> main_ram_cs_o && main_ram_we_o == mw_q && main_ram_addr_o == ma_q;
  endproperty
  a_main_xfer: assert property (p_main_xfer)
    else $error("main transfer target wrong");
  property p_we_idle;
    !main_ram_cs_o |-> main_ram_we_o == WE_NONE;
  endproperty
  a_we_idle: assert property (p_we_idle)
    else $error("lane enable outside strobe");
  property p_copy;
    main_ram_cs_o |-> main_ram_wd_o[111:56] == main_ram_wd_o[55:0];
  endproperty
  a_copy: assert property (p_copy)
    else $error("ways got different copies");
  property p_lock_xfer;
    xl |=> lock_ram_cs_o && lock_ram_addr_o == la_q;
  endproperty
  a_lock_xfer: assert property (p_lock_xfer)
    else $error("lockdown transfer target wrong");
  property p_lock_only;
    lock_ram_cs_o |-> $past(xl);
  endproperty
  a_lock_only: assert property (p_lock_only)
    else $error("spurious lockdown strobe");
  property p_hold;
    !main_ram_cs_o |-> $stable(main_ram_wd_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("main write data moved without strobe");
  property p_perm;
    main_perm_o.user_read |-> main_perm_o.priv_read && main_perm_o.priv_write;
  endproperty
  a_perm: assert property (p_perm)
    else $error("user access without privileged access");
endmodule : tlb_test_access_sva
bind tlb_test_access tlb_test_access_sva u_sva (.clock_i(clock_i),
  .srst_i(srst_i), .cp_op_i(cp_op_i), .cp_rvalid_o(cp_rvalid_o),
  .main_ram_cs_o(main_ram_cs_o), .main_ram_addr_o(main_ram_addr_o),
  .main_ram_we_o(main_ram_we_o), .main_ram_wd_o(main_ram_wd_o),
  .lock_ram_cs_o(lock_ram_cs_o), .lock_ram_addr_o(lock_ram_addr_o),
  .main_perm_o(main_perm_o));
`default_nettype wire

// ==== dv/tb_tlb_test_access.sv ====
// Self-checking testbench for the TLB test access block
`timescale 1ns/100ps
`default_nettype none
module tb_tlb_test_access
  import tlb_test_pkg::*;
;
  logic clock_i, srst_i, cp_rvalid_o, main_ram_cs_o, lock_ram_cs_o;
  logic main_tag_valid_o, main_size_known_o;
  cp_op_t cp_op_i;
  logic [31:0] cp_rdata_o, r, sel, mt, mp, lt, lp;
  logic [4:0] main_ram_addr_o;
  logic [3:0] main_ram_we_o;
  logic [111:0] main_ram_wd_o;
  logic [2:0] lock_ram_addr_o;
  logic [55:0] lock_ram_wd_o;
  perm_t main_perm_o;
  int n_fail, n_tests;
  tlb_test_access u_tlb_test_access (.clock_i(clock_i), .srst_i(srst_i),
    .cp_op_i(cp_op_i), .cp_rdata_o(cp_rdata_o), .cp_rvalid_o(cp_rvalid_o),
    .main_ram_cs_o(main_ram_cs_o), .main_ram_addr_o(main_ram_addr_o),
    .main_ram_we_o(main_ram_we_o), .main_ram_wd_o(main_ram_wd_o),
    .lock_ram_cs_o(lock_ram_cs_o), .lock_ram_addr_o(lock_ram_addr_o),
    .lock_ram_wd_o(lock_ram_wd_o), .main_tag_valid_o(main_tag_valid_o),
    .main_size_known_o(main_size_known_o), .main_perm_o(main_perm_o));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic chk(input string nm, input logic [111:0] s, e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask : chk
  function automatic logic [55:0] pack(input logic [31:0] t, p);
    return {t[31:10], t[3:0], p[31:10], p[7:0]};
  endfunction : pack
  function automatic logic [3:0] perm_exp(input logic [1:0] code);
    case (code)
      2'h0: return 4'h0;
      2'h1: return 4'hc;
      2'h2: return 4'he;
      default: return 4'hf;
    endcase
  endfunction : perm_exp
  // One op per call; its answer is checked one clock later
  task automatic do_op(input logic w, input logic [2:0] o1,
      input logic [3:0] crn, crm, input logic [2:0] o2, input logic [31:0] d);
    logic tl, so, rd, xm, xl;
    logic [31:0] q;
    logic [55:0] e;
    cp_op_i = '{1'h1, w, o1, crn, crm, o2, d};
    so = crn == 4'hf && o1 == 3'h0 && crm == 4'h1 && o2 == 3'h0;
    tl = crn == 4'hf && o1 inside {3'h4, 3'h5} && o2 < 3'h2;
    q = so ? sel : (crm == 4'h2) ? (o2[0] ? lt : mt) : (o2[0] ? lp : mp);
    rd = !w && (so || (tl && crm inside {4'h2, 4'h4}));
    xm = w && tl && crm == 4'h7 && !o2[0];
    xl = w && tl && crm == 4'h7 && o2[0];
    e = o2[0] ? pack(lt, lp) : pack(mt, mp);
    if (w && so) sel = d;
    if (w && tl && crm == 4'h3 && o2[0]) lt = d;
    if (w && tl && crm == 4'h3 && !o2[0]) mt = d;
    if (w && tl && crm == 4'h5 && o2[0]) lp = d;
    if (w && tl && crm == 4'h5 && !o2[0]) mp = d;
    @(negedge clock_i);
    chk("rvalid", cp_rvalid_o, rd);
    if (rd) chk("rdata", cp_rdata_o, q);
    chk("main cs", main_ram_cs_o, xm);
    chk("main we", main_ram_we_o, !xm ? 4'h0 : sel[31] ? 4'hc : 4'h3);
    if (xm) begin
      chk("main addr", main_ram_addr_o, sel[14:10]);
      chk("main wd", main_ram_wd_o, {e, e});
    end
    chk("lock cs", lock_ram_cs_o, xl);
    if (xl) begin
      chk("lock addr", lock_ram_addr_o, sel[28:26]);
      chk("lock wd", lock_ram_wd_o, e);
    end
    chk("valid", main_tag_valid_o, mt[4]);
    chk("size", main_size_known_o,
      mt[3:0] inside {4'h1, 4'h3, 4'h5, 4'h7, 4'hb});
    chk("perm", main_perm_o, perm_exp(mp[3:2]));
  endtask : do_op
  task automatic wr(input logic [2:0] o1, input logic [3:0] crm,
      input logic [2:0] o2, input logic [31:0] d);
    do_op(1'h1, o1, 4'hf, crm, o2, d);
  endtask : wr
  task automatic rdo(input logic [2:0] o1, input logic [3:0] crm,
      input logic [2:0] o2);
    do_op(1'h0, o1, 4'hf, crm, o2, 32'h0);
  endtask : rdo
  task automatic rst(input int n);
    cp_op_i = '0;
    srst_i = 1'h1;
    repeat (n) @(negedge clock_i);
    srst_i = 1'h0;
    {sel, mt, mp, lt, lp} = '0;
    @(negedge clock_i);
    chk("reset state", {cp_rvalid_o, main_ram_cs_o, main_tag_valid_o,
      main_perm_o, cp_rdata_o}, 112'h0);
  endtask : rst
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end
  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    n_fail = 0;
    n_tests = 0;
    void'($urandom(32'haaa6));
    rst(10);
    // Way 1 entry 3 then way 0 entry 31, back to back with read-back
    wr(3'h0, 4'h1, 3'h0, 32'h8000_0c00);
    wr(3'h4, 4'h3, 3'h0, 32'h1234_5c13);
    wr(3'h5, 4'h5, 3'h0, 32'hfedc_bcfb);
    wr(3'h4, 4'h7, 3'h0, 32'h0);
    rdo(3'h5, 4'h2, 3'h0);
    rdo(3'h4, 4'h4, 3'h0);
    rdo(3'h0, 4'h1, 3'h0);
    wr(3'h0, 4'h1, 3'h0, 32'h0000_7c00);
    wr(3'h5, 4'h7, 3'h0, 32'h0);
    $display("test main walk done");
    wr(3'h0, 4'h1, 3'h0, 32'h1c00_0000);
    wr(3'h5, 4'h3, 3'h1, 32'habcd_e41b);
    wr(3'h4, 4'h5, 3'h1, 32'h7654_3ca6);
    wr(3'h4, 4'h7, 3'h1, 32'h0);
    rdo(3'h4, 4'h2, 3'h1);
    rdo(3'h5, 4'h4, 3'h1);
    $display("test lockdown walk done");
    for (int i = 0; i < 16; i++) begin
      r = $urandom;
      wr(3'h4, 4'h3, 3'h0, {r[31:4], 4'(i)});
      wr(3'h5, 4'h5, 3'h0, {r[27:0], 2'(i), 2'(i)});
    end
    $display("test codes done");
    rdo(3'h4, 4'h3, 3'h0);
    rdo(3'h4, 4'h7, 3'h0);
    wr(3'h4, 4'h2, 3'h0, 32'hffff_ffff);
    wr(3'h6, 4'h3, 3'h0, 32'hffff_ffff);
    wr(3'h4, 4'h3, 3'h2, 32'hffff_ffff);
    do_op(1'h1, 3'h4, 4'he, 4'h3, 3'h0, 32'hffff_ffff);
    $display("test refused done");
    for (int k = 0; k < 400; k++) begin
      r = $urandom;
      do_op(r[19], r[1] ? (r[0] ? 3'h4 : 3'h5) : (r[2] ? 3'h0 : r[22:20]),
        r[12:9] == 4'h0 ? r[16:13] : 4'hf,
        r[8] ? r[7:4] : {1'h0, r[6:4]}, {1'h0, r[18:17]}, $urandom);
    end
    $display("test random done");
    rst(3);
    wr(3'h4, 4'h7, 3'h0, 32'h0);
    $display("test reset done");
    cp_op_i = '0;
    finish_test();
  end
endmodule : tb_tlb_test_access
`default_nettype wire
